// [bridge_window_pkg.sv]
// Register map, field layout, reset values and widths of the bridge memory window registers
`default_nettype none
package bridge_window_pkg;
  localparam int ADDR_W = 12;
  localparam int WIN_W = 44;
  // Register indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_SEC_STATUS = 12'h01E;
  localparam logic [ADDR_W-1:0] IDX_MEM_BASE = 12'h020;
  localparam logic [ADDR_W-1:0] IDX_MEM_LIMIT = 12'h022;
  localparam logic [ADDR_W-1:0] IDX_PREF_BASE = 12'h024;
  localparam logic [ADDR_W-1:0] IDX_PREF_LIMIT = 12'h026;
  localparam logic [ADDR_W-1:0] IDX_PREF_BASE_HIGH = 12'h028;
  localparam logic [ADDR_W-1:0] IDX_PREF_LIMIT_HIGH = 12'h02C;
  localparam logic [ADDR_W-1:0] IDX_BRIDGE_CTRL = 12'h03E;
  localparam logic [ADDR_W-1:0] IDX_CFG_LOCK = 12'h040;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h041;
  localparam logic [ADDR_W-1:0] ADDR_SEC_STATUS = ADDR_W'(IDX_SEC_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_MEM_BASE = ADDR_W'(IDX_MEM_BASE * 4);
  localparam logic [ADDR_W-1:0] ADDR_MEM_LIMIT = ADDR_W'(IDX_MEM_LIMIT * 4);
  localparam logic [ADDR_W-1:0] ADDR_PREF_BASE = ADDR_W'(IDX_PREF_BASE * 4);
  localparam logic [ADDR_W-1:0] ADDR_PREF_LIMIT = ADDR_W'(IDX_PREF_LIMIT * 4);
  localparam logic [ADDR_W-1:0] ADDR_PREF_BASE_HIGH = ADDR_W'(IDX_PREF_BASE_HIGH * 4);
  localparam logic [ADDR_W-1:0] ADDR_PREF_LIMIT_HIGH = ADDR_W'(IDX_PREF_LIMIT_HIGH * 4);
  localparam logic [ADDR_W-1:0] ADDR_BRIDGE_CTRL = ADDR_W'(IDX_BRIDGE_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_CFG_LOCK = ADDR_W'(IDX_CFG_LOCK * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = ADDR_W'(IDX_IRQ_MASK * 4);
  // Field positions
  localparam int BIT_RX_MASTER_ABORT = 13;
  localparam int BIT_RX_SYSTEM_ERROR = 14;
  localparam int BIT_DETECTED_POISON = 15;
  localparam int BIT_ADDR64 = 0;
  localparam int WIN_LSB = 4;
  localparam int WIN_MSB = 15;
  localparam int BIT_SERR_ENABLE = 1;
  localparam int BIT_UNLOCK = 0;
  // Reset values and AXI response codes
  localparam logic [11:0] MEM_BASE_RST = 12'hFFF;
  localparam logic [11:0] MEM_LIMIT_RST = 12'h000;
  localparam logic [11:0] PREF_BASE_RST = 12'hFFF;
  localparam logic [11:0] PREF_LIMIT_RST = 12'h000;
  localparam logic ADDR64_RST = 1'b1;
  localparam logic [31:0] PREF_BASE_HIGH_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] PREF_LIMIT_HIGH_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : bridge_window_pkg
`default_nettype wire

// [window_match.sv]
// Registered address window comparator on address bits 63..20
`default_nettype none
module window_match
  import bridge_window_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [63:0] i_addr,
  input wire logic [WIN_W-1:0] i_low,
  input wire logic [WIN_W-1:0] i_high,
  output logic o_hit
);
  logic next_hit;

  // Bits 19..0 are don't-care: the base is 1MB aligned and the limit ends at 0xF_FFFF
  always_comb
  begin
    next_hit = (i_addr[63:20] >= i_low) && (i_addr[63:20] <= i_high);
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_hit <= 1'b0;
    else
      o_hit <= next_hit;
  end
endmodule : window_match
`default_nettype wire

// [bridge_memory_window_regs.sv]
// Secondary status, memory and prefetchable window registers with AXI4-Lite access
`default_nettype none
// Functional notes
// (R1) Received master abort bit reads zero
// (R2) No system error flag without enable
// (R3) Error message sets flag; write one clears
// (R4) Poisoned TLP always sets poison flag
// (R5) Memory window decides non-prefetchable forwarding
// (R6) Memory base field, 1MB aligned, resets FFF
// (R7) Memory limit field, resets zero
// (R8) Prefetch base, limit, upper halves decide forwarding
// (R9) 64-bit capable bit, resets one, lockable
// (R10) Limit bit 0 mirrors capable bit
// (R11) Prefetch base field, resets FFF
// (R12) Prefetch limit field, resets zero
// (R13) Upper halves read zero when 32-bit
// (R14) Reserved bits read zero, ignore writes
module bridge_memory_window_regs
  import bridge_window_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_RX_ERR_MSG,
  input wire logic I_RX_POISON,
  input wire logic [63:0] I_FWD_ADDR,
  output logic O_MEM_HIT,
  output logic O_PREF_HIT,
  output logic O_IRQ
);
  logic rst_meta;
  logic rst_n;
  logic aw_held, next_aw_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [11:0] memory_window_base, next_memory_window_base;
  logic [11:0] memory_window_limit, next_memory_window_limit;
  logic [11:0] prefetch_window_base, next_prefetch_window_base;
  logic [11:0] prefetch_window_limit, next_prefetch_window_limit;
  logic prefetch_addr64_capable, next_prefetch_addr64_capable;
  logic [31:0] prefetch_base_high, next_prefetch_base_high;
  logic [31:0] prefetch_limit_high, next_prefetch_limit_high;
  logic rx_system_error_flag, next_rx_system_error_flag;
  logic detected_poison_flag, next_detected_poison_flag;
  logic system_error_enable, next_system_error_enable;
  logic cfg_unlock, next_cfg_unlock;
  logic [1:0] irq_mask, next_irq_mask;
  logic wr_fire;
  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] ra;
  logic [31:0] merged;
  logic [31:0] read_word;
  logic read_hit;
  logic wr_hit;
  logic [31:0] base_high_view;
  logic [31:0] limit_high_view;
  logic [WIN_W-1:0] mem_low, mem_high, pref_low, pref_high;

  // Only bytes whose strobe is set are replaced
  function automatic logic [31:0] lane_merge(input logic [31:0] cur, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = cur;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : lane_merge

  always_ff @(posedge I_REF_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign O_AWREADY = !aw_held && !bvalid;
  assign O_WREADY = !w_held && !bvalid;
  assign O_ARREADY = !rvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wa = {aw_addr[ADDR_W-1:2], 2'b00};
  assign ra = {I_ARADDR[ADDR_W-1:2], 2'b00};
  assign base_high_view = prefetch_addr64_capable ? prefetch_base_high : 32'h0000_0000; // (R13)
  assign limit_high_view = prefetch_addr64_capable ? prefetch_limit_high : 32'h0000_0000; // (R13)

  // Read mux; unlisted and reserved bits stay zero
  always_comb
  begin
    read_word = 32'h0000_0000;
    read_hit = 1'b1;
    case (ra)
      ADDR_SEC_STATUS:
      begin
        read_word[BIT_DETECTED_POISON] = detected_poison_flag;
        read_word[BIT_RX_SYSTEM_ERROR] = rx_system_error_flag;
        read_word[BIT_RX_MASTER_ABORT] = 1'b0; // (R1)
      end
      ADDR_MEM_BASE: read_word[WIN_MSB:WIN_LSB] = memory_window_base; // (R14)
      ADDR_MEM_LIMIT: read_word[WIN_MSB:WIN_LSB] = memory_window_limit; // (R14)
      ADDR_PREF_BASE:
      begin
        read_word[WIN_MSB:WIN_LSB] = prefetch_window_base;
        read_word[BIT_ADDR64] = prefetch_addr64_capable;
      end
      ADDR_PREF_LIMIT:
      begin
        read_word[WIN_MSB:WIN_LSB] = prefetch_window_limit;
        read_word[BIT_ADDR64] = prefetch_addr64_capable; // (R10)
      end
      ADDR_PREF_BASE_HIGH: read_word = base_high_view; // (R13)
      ADDR_PREF_LIMIT_HIGH: read_word = limit_high_view; // (R13)
      ADDR_BRIDGE_CTRL: read_word[BIT_SERR_ENABLE] = system_error_enable;
      ADDR_CFG_LOCK: read_word[BIT_UNLOCK] = cfg_unlock;
      ADDR_IRQ_MASK: read_word[BIT_DETECTED_POISON:BIT_RX_SYSTEM_ERROR] = irq_mask;
      default: read_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_memory_window_base = memory_window_base;
    next_memory_window_limit = memory_window_limit;
    next_prefetch_window_base = prefetch_window_base;
    next_prefetch_window_limit = prefetch_window_limit;
    next_prefetch_addr64_capable = prefetch_addr64_capable;
    next_prefetch_base_high = prefetch_base_high;
    next_prefetch_limit_high = prefetch_limit_high;
    next_system_error_enable = system_error_enable;
    next_cfg_unlock = cfg_unlock;
    next_irq_mask = irq_mask;
    next_rx_system_error_flag = rx_system_error_flag;
    next_detected_poison_flag = detected_poison_flag;
    wr_hit = 1'b1;
    merged = 32'h0000_0000;
    if (I_AWVALID && O_AWREADY)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = I_AWADDR;
    end
    if (I_WVALID && O_WREADY)
    begin
      next_w_held = 1'b1;
      next_w_data = I_WDATA;
      next_w_strb = I_WSTRB;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      case (wa)
        ADDR_SEC_STATUS:
        begin
          // Write one clears; the set terms below are applied after and win
          if (w_strb[1] && w_data[BIT_RX_SYSTEM_ERROR])
            next_rx_system_error_flag = 1'b0; // (R3)
          if (w_strb[1] && w_data[BIT_DETECTED_POISON])
            next_detected_poison_flag = 1'b0; // (R4)
        end
        ADDR_MEM_BASE:
        begin
          merged = lane_merge({16'h0000, memory_window_base, 4'h0}, w_data, w_strb);
          next_memory_window_base = merged[WIN_MSB:WIN_LSB]; // (R6) (R14)
        end
        ADDR_MEM_LIMIT:
        begin
          merged = lane_merge({16'h0000, memory_window_limit, 4'h0}, w_data, w_strb);
          next_memory_window_limit = merged[WIN_MSB:WIN_LSB]; // (R7) (R14)
        end
        ADDR_PREF_BASE:
        begin
          merged = lane_merge({16'h0000, prefetch_window_base, 3'h0, prefetch_addr64_capable}, w_data, w_strb);
          next_prefetch_window_base = merged[WIN_MSB:WIN_LSB]; // (R11)
          if (cfg_unlock)
            next_prefetch_addr64_capable = merged[BIT_ADDR64]; // (R9)
        end
        ADDR_PREF_LIMIT:
        begin
          merged = lane_merge({16'h0000, prefetch_window_limit, 4'h0}, w_data, w_strb);
          next_prefetch_window_limit = merged[WIN_MSB:WIN_LSB]; // (R12)
        end
        ADDR_PREF_BASE_HIGH:
        begin
          if (prefetch_addr64_capable)
            next_prefetch_base_high = lane_merge(prefetch_base_high, w_data, w_strb); // (R13)
        end
        ADDR_PREF_LIMIT_HIGH:
        begin
          if (prefetch_addr64_capable)
            next_prefetch_limit_high = lane_merge(prefetch_limit_high, w_data, w_strb); // (R13)
        end
        ADDR_BRIDGE_CTRL:
        begin
          if (w_strb[0])
            next_system_error_enable = w_data[BIT_SERR_ENABLE];
        end
        ADDR_CFG_LOCK:
        begin
          if (w_strb[0])
            next_cfg_unlock = w_data[BIT_UNLOCK];
        end
        ADDR_IRQ_MASK:
        begin
          if (w_strb[1])
            next_irq_mask = w_data[BIT_DETECTED_POISON:BIT_RX_SYSTEM_ERROR];
        end
        default: wr_hit = 1'b0;
      endcase
      next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid && I_BREADY)
      next_bvalid = 1'b0;
    if (I_RX_ERR_MSG && system_error_enable)
      next_rx_system_error_flag = 1'b1; // (R2) (R3)
    if (I_RX_POISON)
      next_detected_poison_flag = 1'b1; // (R4)
    if (I_ARVALID && O_ARREADY)
    begin
      next_rvalid = 1'b1;
      next_rdata = read_word;
      next_rresp = read_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && I_RREADY)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      memory_window_base <= MEM_BASE_RST;
      memory_window_limit <= MEM_LIMIT_RST;
      prefetch_window_base <= PREF_BASE_RST;
      prefetch_window_limit <= PREF_LIMIT_RST;
      prefetch_addr64_capable <= ADDR64_RST;
      prefetch_base_high <= PREF_BASE_HIGH_RST;
      prefetch_limit_high <= PREF_LIMIT_HIGH_RST;
      rx_system_error_flag <= 1'b0;
      detected_poison_flag <= 1'b0;
      system_error_enable <= 1'b0;
      cfg_unlock <= 1'b0;
      irq_mask <= 2'b00;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      memory_window_base <= next_memory_window_base;
      memory_window_limit <= next_memory_window_limit;
      prefetch_window_base <= next_prefetch_window_base;
      prefetch_window_limit <= next_prefetch_window_limit;
      prefetch_addr64_capable <= next_prefetch_addr64_capable;
      prefetch_base_high <= next_prefetch_base_high;
      prefetch_limit_high <= next_prefetch_limit_high;
      rx_system_error_flag <= next_rx_system_error_flag;
      detected_poison_flag <= next_detected_poison_flag;
      system_error_enable <= next_system_error_enable;
      cfg_unlock <= next_cfg_unlock;
      irq_mask <= next_irq_mask;
    end
  end

  assign O_BVALID = bvalid;
  assign O_BRESP = bresp;
  assign O_RVALID = rvalid;
  assign O_RDATA = rdata;
  assign O_RRESP = rresp;
  assign O_IRQ = |({detected_poison_flag, rx_system_error_flag} & irq_mask);

  // A 32-bit window keeps its upper half at zero, so 64-bit addresses never hit
  assign mem_low = {32'h0000_0000, memory_window_base}; // (R5)
  assign mem_high = {32'h0000_0000, memory_window_limit}; // (R5)
  assign pref_low = {base_high_view, prefetch_window_base}; // (R8) (R11)
  assign pref_high = {limit_high_view, prefetch_window_limit}; // (R8) (R12)

  window_match mem_window (
    .i_clk(I_REF_CLK),
    .i_rst_n(rst_n),
    .i_addr(I_FWD_ADDR),
    .i_low(mem_low),
    .i_high(mem_high),
    .o_hit(O_MEM_HIT)
  );

  window_match pref_window (
    .i_clk(I_REF_CLK),
    .i_rst_n(rst_n),
    .i_addr(I_FWD_ADDR),
    .i_low(pref_low),
    .i_high(pref_high),
    .o_hit(O_PREF_HIT)
  );

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!rst_n);

  abort_zero_a: assert property ((I_ARVALID && O_ARREADY && ra == ADDR_SEC_STATUS) |=> !O_RDATA[13]) // (R1)
    else $error("master abort bit read nonzero");
  syserr_gate_a: assert property ((!system_error_enable && !rx_system_error_flag) |=> !rx_system_error_flag) // (R2)
    else $error("system error flag set while disabled");
  syserr_set_a: assert property ((I_RX_ERR_MSG && system_error_enable) |=> rx_system_error_flag) // (R3)
    else $error("system error flag not set");
  poison_set_a: assert property (I_RX_POISON |=> detected_poison_flag) // (R4)
    else $error("poison flag not set");
  poison_clear_a: assert property ((wr_fire && wa == ADDR_SEC_STATUS && w_strb[1] && w_data[15] && !I_RX_POISON)
    |=> !detected_poison_flag) // (R4)
    else $error("poison flag not cleared by write one");
  mem_hit_a: assert property (##1 O_MEM_HIT == ($past(I_FWD_ADDR[63:32]) == 32'h0000_0000
    && $past(I_FWD_ADDR[31:20]) >= $past(memory_window_base)
    && $past(I_FWD_ADDR[31:20]) <= $past(memory_window_limit))) // (R5)
    else $error("memory window hit wrong");
  base_reset_a: assert property ($rose(rst_n) |-> memory_window_base == 12'hFFF && memory_window_limit == 12'h000
    && prefetch_window_base == 12'hFFF && prefetch_addr64_capable) // (R6)
    else $error("window reset value wrong");
  cap_lock_a: assert property (!cfg_unlock |=> $stable(prefetch_addr64_capable)) // (R9)
    else $error("capable bit changed while locked");
  limit_mirror_a: assert property ((I_ARVALID && O_ARREADY && ra == ADDR_PREF_LIMIT)
    |=> O_RDATA[0] == $past(prefetch_addr64_capable)) // (R10)
    else $error("limit capable bit does not mirror");
  upper_zero_a: assert property ((I_ARVALID && O_ARREADY && ra == ADDR_PREF_BASE_HIGH && !prefetch_addr64_capable)
    |=> O_RDATA == 32'h0000_0000) // (R13)
    else $error("upper base nonzero in 32-bit mode");
  reserved_zero_a: assert property ((I_ARVALID && O_ARREADY && (ra == ADDR_MEM_BASE || ra == ADDR_MEM_LIMIT))
    |=> O_RDATA[3:0] == 4'h0 && O_RDATA[31:16] == 16'h0000) // (R14)
    else $error("reserved bits read nonzero");
  pref_hit_a: assert property ((!prefetch_addr64_capable && I_FWD_ADDR[63:32] != 32'h0000_0000) |=> !O_PREF_HIT) // (R8)
    else $error("32-bit prefetch window hit high address");

  syserr_cover_c: cover property (I_RX_ERR_MSG && system_error_enable ##1 rx_system_error_flag);
  clear_cover_c: cover property (wr_fire && wa == ADDR_SEC_STATUS ##1 !detected_poison_flag);
  mem_cover_c: cover property (O_MEM_HIT);
  pref64_cover_c: cover property (O_PREF_HIT && prefetch_addr64_capable && prefetch_base_high != 32'h0000_0000);
endmodule : bridge_memory_window_regs
`default_nettype wire

// [tb_bridge_memory_window_regs.sv]
// Self-checking bench for the bridge memory window registers
`default_nettype none
module tb_bridge_memory_window_regs
  import bridge_window_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, err_msg, poison;
  logic awready, wready, bvalid, arready, rvalid, mem_hit, pref_hit, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [63:0] fwd_addr;
  int fail_count, checks_done;

  bridge_memory_window_regs dut_u (
    .I_REF_CLK(clk), .I_RESETN(rstn),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_RX_ERR_MSG(err_msg), .I_RX_POISON(poison), .I_FWD_ADDR(fwd_addr),
    .O_MEM_HIT(mem_hit), .O_PREF_HIT(pref_hit), .O_IRQ(irq)
  );

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic tmo;
    fail_count++;
    $display("ERROR bus handshake expected answer seen none");
    end_sim();
  endtask : tmo

  // Called just after a rising edge; handshakes are judged at the falling edge where outputs are settled
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw, w;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 50; n++)
    begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      if (bvalid)
      begin
        check("bresp", 32'(er), 32'(bresp));
        @(posedge clk);
        bready <= 1'h0;
        return;
      end
      @(posedge clk);
      if (aw)
        awvalid <= 1'h0;
      if (w)
        wvalid <= 1'h0;
    end
    tmo();
  endtask : wr

  task automatic rdc(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                     input logic [1:0] er = RESP_OKAY);
    logic ar;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 50; n++)
    begin
      @(negedge clk);
      ar = arvalid && arready;
      if (rvalid)
      begin
        check(name, exp, rdata);
        check("rresp", 32'(er), 32'(rresp));
        @(posedge clk);
        rready <= 1'h0;
        return;
      end
      @(posedge clk);
      if (ar)
        arvalid <= 1'h0;
    end
    tmo();
  endtask : rdc

  task automatic ev(input logic e, input logic p);
    @(posedge clk);
    err_msg <= e;
    poison <= p;
    @(posedge clk);
    err_msg <= 1'h0;
    poison <= 1'h0;
  endtask : ev

  // Hit flags are registered, so they answer at the first edge after the address is applied
  task automatic fwd(input logic [63:0] a, input logic m, input logic p);
    fwd_addr <= a;
    @(posedge clk);
    @(negedge clk);
    check("mem_hit", 32'(m), 32'(mem_hit));
    check("pref_hit", 32'(p), 32'(pref_hit));
    @(posedge clk);
  endtask : fwd

  task automatic chk_irq(input logic e);
    @(negedge clk);
    check("irq", 32'(e), 32'(irq));
    @(posedge clk);
  endtask : chk_irq

  task automatic t_reset;
    rdc("mem base", ADDR_MEM_BASE, 32'h0000_FFF0);
    rdc("mem limit", ADDR_MEM_LIMIT, 32'h0);
    rdc("pref base", ADDR_PREF_BASE, 32'h0000_FFF1);
    rdc("pref limit", ADDR_PREF_LIMIT, 32'h0000_0001);
    rdc("base high", ADDR_PREF_BASE_HIGH, 32'hFFFF_FFFF);
    rdc("limit high", ADDR_PREF_LIMIT_HIGH, 32'h0);
    rdc("status", ADDR_SEC_STATUS, 32'h0);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_window;
    wr(ADDR_MEM_BASE, 32'hFFFF_123F);
    wr(ADDR_MEM_LIMIT, 32'h0000_125F);
    rdc("mem base", ADDR_MEM_BASE, 32'h0000_1230);
    rdc("mem limit", ADDR_MEM_LIMIT, 32'h0000_1250);
    fwd(64'h0000_0000_1230_0000, 1'h1, 1'h0);
    fwd(64'h0000_0000_125F_FFFF, 1'h1, 1'h0);
    fwd(64'h0000_0000_1260_0000, 1'h0, 1'h0);
    fwd(64'h0000_0000_122F_FFFF, 1'h0, 1'h0);
    fwd(64'h0000_0001_1230_0000, 1'h0, 1'h0);
    wr(ADDR_PREF_BASE_HIGH, 32'h0000_0001);
    wr(ADDR_PREF_LIMIT_HIGH, 32'h0000_0001);
    // Bit 0 written low while locked must be ignored
    wr(ADDR_PREF_BASE, 32'h0000_400E);
    wr(ADDR_PREF_LIMIT, 32'h0000_410E);
    rdc("pref base", ADDR_PREF_BASE, 32'h0000_4001);
    rdc("pref limit", ADDR_PREF_LIMIT, 32'h0000_4101);
    fwd(64'h0000_0001_4000_0000, 1'h0, 1'h1);
    fwd(64'h0000_0001_410F_FFFF, 1'h0, 1'h1);
    fwd(64'h0000_0001_4110_0000, 1'h0, 1'h0);
    fwd(64'h0000_0000_4000_0000, 1'h0, 1'h0);
    $display("test windows done");
  endtask : t_window

  task automatic t_cap;
    wr(ADDR_CFG_LOCK, 32'h0000_0001);
    wr(ADDR_PREF_BASE, 32'h0000_4000);
    rdc("pref base", ADDR_PREF_BASE, 32'h0000_4000);
    rdc("pref limit", ADDR_PREF_LIMIT, 32'h0000_4100);
    rdc("base high", ADDR_PREF_BASE_HIGH, 32'h0);
    wr(ADDR_PREF_LIMIT_HIGH, 32'h0000_0005);
    rdc("limit high", ADDR_PREF_LIMIT_HIGH, 32'h0);
    fwd(64'h0000_0000_4000_0000, 1'h0, 1'h1);
    fwd(64'h0000_0001_4000_0000, 1'h0, 1'h0);
    $display("test capability done");
  endtask : t_cap

  task automatic t_status;
    ev(1'h1, 1'h0);
    rdc("status", ADDR_SEC_STATUS, 32'h0);
    wr(ADDR_BRIDGE_CTRL, 32'h0000_0002);
    ev(1'h1, 1'h0);
    rdc("status", ADDR_SEC_STATUS, 32'h0000_4000);
    ev(1'h0, 1'h1);
    rdc("status", ADDR_SEC_STATUS, 32'h0000_C000);
    chk_irq(1'h0);
    wr(ADDR_IRQ_MASK, 32'h0000_8000);
    chk_irq(1'h1);
    // Mask only the system error bit, so its own path drives the interrupt
    wr(ADDR_IRQ_MASK, 32'h0000_4000);
    chk_irq(1'h1);
    wr(ADDR_SEC_STATUS, 32'h0000_6000);
    rdc("status", ADDR_SEC_STATUS, 32'h0000_8000);
    chk_irq(1'h0);
    wr(ADDR_IRQ_MASK, 32'h0000_8000);
    chk_irq(1'h1);
    wr(ADDR_SEC_STATUS, 32'h0000_8000);
    rdc("status", ADDR_SEC_STATUS, 32'h0);
    chk_irq(1'h0);
    $display("test status flags done");
  endtask : t_status

  task automatic t_unmapped;
    wr(12'h200, 32'h1234_5678, RESP_SLVERR);
    rdc("unmapped", 12'h200, 32'h0, RESP_SLVERR);
    $display("test unmapped done");
  endtask : t_unmapped

  initial
  begin
    rstn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, err_msg, poison} = 7'h00;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    wstrb = 4'hF;
    fwd_addr = 64'h0;
    fail_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    // The internal reset copy needs two more edges to clear
    repeat (3) @(posedge clk);
    t_reset();
    t_window();
    t_cap();
    t_status();
    t_unmapped();
    end_sim();
  end
endmodule : tb_bridge_memory_window_regs
`default_nettype wire
